// ===== src/dbg_run_control.sv
/*
 debug run control: control register, run state, comparator cycle-type
 qualification and cpu break requests (tag or force).
 assumes trigger decoding is done outside and presented as trigger_hit;
 trace fifo lives outside and reports stores via bus_event.
*/
`timescale 1ns/1ps
`default_nettype none
module dbg_run_control
	import dbg_ctrl_pkg::*;
#(
	parameter int unsigned fifo_depth = 8
) (
	input  wire logic                 clock,          // bus clock
	input  wire logic                 nrst,           // async reset, low
	input  wire logic [addr_w-1:0]    addr,           // register address
	input  wire logic [7:0]           wdata,          // write data
	input  wire logic                 wr,             // write strobe
	input  wire logic                 rd,             // read strobe
	output logic      [7:0]           rdata,          // read data, next cycle
	input  wire logic                 secured,        // device secured
	input  wire logic                 begin_trace,    // 1 begin, 0 end run
	input  wire dbg_ctrl_pkg::bus_event_t bus_event,  // comparator and fifo
	input  wire logic                 trigger_hit,    // trigger condition met
	output logic                      armed,          // compare and store on
	output logic                      match_a,        // qualified a match
	output logic                      match_b,        // qualified b match
	output logic                      run_active_flag,// run in progress
	output dbg_ctrl_pkg::brk_req_t    brk_req         // cpu break request
);
	import dbg_ctrl_pkg::*;

	localparam int unsigned cnt_w = $clog2(fifo_depth + 1);

	ctrl_t              ctrl, next_ctrl;
	logic               run, next_run;
	logic               flag_a, next_flag_a;
	logic               flag_b, next_flag_b;
	logic [cnt_w-1:0]   count, next_count;
	logic [7:0]         next_rdata;
	logic               next_match_a, next_match_b;
	brk_req_t           next_brk;
	logic               fifo_full_now, done, brk_fire;
	logic               ctrl_write;

	// one decode for the control write, shared by logic and checks
	assign ctrl_write = wr && (addr == ctrl_offset);

	// qualify a raw comparator hit by bus cycle type
	function automatic logic qualify(input logic hit, input logic en,
		input logic want_read, input logic is_read);
		qualify = hit && (!en || (want_read == is_read));
	endfunction

	always_comb begin
		next_match_a = run && qualify(bus_event.a_hit,
			ctrl.cycle_qualify_a_enable, ctrl.cycle_type_a,
			bus_event.is_read);
		next_match_b = run && qualify(bus_event.b_hit,
			ctrl.cycle_qualify_b_enable, ctrl.cycle_type_b,
			bus_event.is_read);
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			match_a <= 1'b0;
			match_b <= 1'b0;
		end else begin
			match_a <= next_match_a;
			match_b <= next_match_b;
		end
	end

	// store counting continues regardless of break enable
	assign fifo_full_now = run && bus_event.store &&
		(count == cnt_w'(fifo_depth - 1));
	// break timing independent of opcode qualification
	assign done = begin_trace ? fifo_full_now
		: (run && trigger_hit);
	assign brk_fire = done && ctrl.break_request_enable;

	always_comb begin
		next_ctrl  = ctrl;
		next_run   = run;
		next_flag_a = flag_a || (run && next_match_a);
		next_flag_b = flag_b || (run && next_match_b);
		next_count = count;
		if (run && bus_event.store && count != cnt_w'(fifo_depth))
			next_count = count + cnt_w'(1);
		if (done) begin
			next_ctrl.arm = 1'b0;
			next_run = 1'b0;
		end
		if (ctrl_write) begin
			next_ctrl = ctrl_t'(wdata);
			// a secured part may clear the enable but never set it
			if (secured)
				next_ctrl.debug_module_enable =
					ctrl.debug_module_enable && wdata[bit_enable];
			if (!wdata[bit_arm] || !next_ctrl.debug_module_enable) begin
				next_ctrl.arm = 1'b0;
				next_run = 1'b0;
			end else begin
				next_run = 1'b1;
				next_flag_a = 1'b0;
				next_flag_b = 1'b0;
				next_count = '0;
			end
		end
	end

	always_comb begin
		next_rdata = 8'h00;
		if (rd) begin
			unique case (addr)
				ctrl_offset:   next_rdata = ctrl;
				status_offset: next_rdata = {flag_a, flag_b, run, 1'b0,
					4'(count)};
				default:       next_rdata = 8'h00;
			endcase
		end
		next_brk = '0;
		if (brk_fire) begin
			next_brk.tag_req   = ctrl.tag_select;
			next_brk.force_req = !ctrl.tag_select;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ctrl            <= ctrl_t'(ctrl_reset);
			run             <= 1'b0;
			flag_a          <= 1'b0;
			flag_b          <= 1'b0;
			count           <= '0;
			rdata           <= 8'h00;
			brk_req         <= '0;
			armed           <= 1'b0;
			run_active_flag <= 1'b0;
		end else begin
			ctrl            <= next_ctrl;
			run             <= next_run;
			flag_a          <= next_flag_a;
			flag_b          <= next_flag_b;
			count           <= next_count;
			rdata           <= next_rdata;
			brk_req         <= next_brk;
			armed           <= next_ctrl.arm;
			run_active_flag <= next_run;
		end
	end

	// security and enable
	secure_block_a: assert property (
		@(posedge clock) disable iff (!nrst)
		(secured && !ctrl.debug_module_enable)
		|=> !ctrl.debug_module_enable)
		else $error("enable set while secured");
	secure_keep_a: assert property (
		@(posedge clock) disable iff (!nrst)
		(ctrl_write && !secured)
		|=> ctrl.debug_module_enable == $past(wdata[bit_enable]))
		else $error("enable write lost");
	stop_enable_a: assert property (
		@(posedge clock) disable iff (!nrst)
		(ctrl_write && !wdata[bit_enable]) |=> !run)
		else $error("enable clear left run going");

	// run start, stop and completion; a write wins over completion
	arm_sets_run_a: assert property (
		@(posedge clock) disable iff (!nrst)
		(ctrl_write && wdata[bit_arm] && wdata[bit_enable] && !secured)
		|=> (run && ctrl.arm && flag_a == 1'b0))
		else $error("arm write did not start run");
	arm_clears_a: assert property (
		@(posedge clock) disable iff (!nrst)
		(ctrl_write && next_run)
		|=> (!flag_a && !flag_b && count == '0))
		else $error("arming left flags or count");
	stop_write_a: assert property (
		@(posedge clock) disable iff (!nrst)
		(ctrl_write && !wdata[bit_arm]) |=> !run)
		else $error("stop write left run going");
	done_clears_a: assert property (
		@(posedge clock) disable iff (!nrst)
		(done && !ctrl_write) |=> !ctrl.arm)
		else $error("arm not cleared at completion");
	done_stops_a: assert property (
		@(posedge clock) disable iff (!nrst)
		(done && !ctrl_write) |=> (!armed && !run_active_flag))
		else $error("run still flagged after completion");

	// compare and store only while armed; count stops at the depth
	unarmed_quiet_a: assert property (
		@(posedge clock) disable iff (!nrst)
		!run |=> (!match_a && !match_b))
		else $error("match while unarmed");
	store_count_a: assert property (
		@(posedge clock) disable iff (!nrst)
		(run && bus_event.store && !ctrl_write
		&& count != cnt_w'(fifo_depth))
		|=> count == $past(count) + cnt_w'(1))
		else $error("store not counted");
	count_bound_a: assert property (
		@(posedge clock) disable iff (!nrst)
		count <= cnt_w'(fifo_depth))
		else $error("count past fifo depth");

	// break requests: gate, type and timing
	brk_gate_a: assert property (
		@(posedge clock) disable iff (!nrst)
		!ctrl.break_request_enable |=> brk_req == '0)
		else $error("break without break enable");
	tag_no_effect_a: assert property (
		@(posedge clock) disable iff (!nrst)
		(!ctrl.break_request_enable && ctrl.tag_select)
		|=> (!brk_req.tag_req && !brk_req.force_req))
		else $error("tag select acted while breaks off");
	brk_type_a: assert property (
		@(posedge clock) disable iff (!nrst)
		brk_fire |=> (brk_req.tag_req == $past(ctrl.tag_select)
		&& brk_req.force_req != $past(ctrl.tag_select)))
		else $error("break type wrong");
	tag_type_a: assert property (
		@(posedge clock) disable iff (!nrst)
		(done && ctrl.break_request_enable && ctrl.tag_select)
		|=> (brk_req.tag_req && !brk_req.force_req))
		else $error("tag break missing");
	force_type_a: assert property (
		@(posedge clock) disable iff (!nrst)
		(done && ctrl.break_request_enable && !ctrl.tag_select)
		|=> (brk_req.force_req && !brk_req.tag_req))
		else $error("force break missing");
	end_trace_a: assert property (
		@(posedge clock) disable iff (!nrst)
		(run && !begin_trace && trigger_hit
		&& ctrl.break_request_enable && !ctrl_write)
		|=> (brk_req != '0 && !run_active_flag))
		else $error("end trace break missing");
	begin_full_a: assert property (
		@(posedge clock) disable iff (!nrst)
		(run && begin_trace && bus_event.store
		&& ctrl.break_request_enable
		&& count == cnt_w'(fifo_depth - 1)) |=> brk_req != '0)
		else $error("begin trace break missing at full");
	begin_trig_a: assert property (
		@(posedge clock) disable iff (!nrst)
		(run && begin_trace && trigger_hit && !fifo_full_now
		&& !ctrl_write) |=> (brk_req == '0 && run_active_flag))
		else $error("begin trace ended before full");

	// comparator cycle-type qualification
	qual_a_a: assert property (
		@(posedge clock) disable iff (!nrst)
		(run && ctrl.cycle_qualify_a_enable && bus_event.a_hit &&
		bus_event.is_read != ctrl.cycle_type_a) |=> !match_a)
		else $error("comparator a matched wrong cycle");
	any_cycle_a_a: assert property (
		@(posedge clock) disable iff (!nrst)
		(run && !ctrl.cycle_qualify_a_enable && bus_event.a_hit)
		|=> match_a)
		else $error("comparator a hit lost");
	qual_b_a: assert property (
		@(posedge clock) disable iff (!nrst)
		(run && ctrl.cycle_qualify_b_enable && bus_event.b_hit &&
		bus_event.is_read != ctrl.cycle_type_b) |=> !match_b)
		else $error("comparator b matched wrong cycle");
	any_cycle_b_a: assert property (
		@(posedge clock) disable iff (!nrst)
		(run && !ctrl.cycle_qualify_b_enable && bus_event.b_hit)
		|=> match_b)
		else $error("comparator b hit lost");

	// register port: read data stands one cycle, zero otherwise
	read_back_a: assert property (
		@(posedge clock) disable iff (!nrst)
		(rd && addr == ctrl_offset) |=> rdata == $past(ctrl))
		else $error("control readback wrong");
	status_read_a: assert property (
		@(posedge clock) disable iff (!nrst)
		(rd && addr == status_offset) |=> rdata[5] == $past(run))
		else $error("status run bit wrong");
	rdata_idle_a: assert property (
		@(posedge clock) disable iff (!nrst)
		!rd |=> rdata == 8'h00)
		else $error("read data outside read cycle");

	cov_arm_c: cover property (@(posedge clock) disable iff (!nrst)
		!run ##1 run);
	cov_tag_c: cover property (@(posedge clock) disable iff (!nrst)
		brk_req.tag_req);
	cov_force_c: cover property (@(posedge clock) disable iff (!nrst)
		brk_req.force_req);
	cov_full_c: cover property (@(posedge clock) disable iff (!nrst)
		begin_trace && fifo_full_now);
	cov_stop_c: cover property (@(posedge clock) disable iff (!nrst)
		run && ctrl_write && !next_run);
endmodule
`default_nettype wire

// ===== src/dbg_ctrl_pkg.sv
/*
 debug run control package: register offsets, control field positions,
 reset values and the carrier structs shared by the run control block.
 assumes an 8-bit register port with one-cycle read latency.
*/
package dbg_ctrl_pkg;

	localparam int unsigned addr_w = 2;
	localparam logic [1:0] ctrl_offset   = 2'h0;
	localparam logic [1:0] status_offset = 2'h1;

	localparam int unsigned bit_enable   = 7;
	localparam int unsigned bit_arm      = 6;
	localparam int unsigned bit_tag      = 5;
	localparam int unsigned bit_brk      = 4;
	localparam int unsigned bit_rw_a     = 3;
	localparam int unsigned bit_rw_a_en  = 2;
	localparam int unsigned bit_rw_b     = 1;
	localparam int unsigned bit_rw_b_en  = 0;

	localparam logic [7:0] ctrl_reset   = 8'h00;
	localparam logic [3:0] count_reset  = 4'h0;

	typedef struct packed {
		logic debug_module_enable;
		logic arm;
		logic tag_select;
		logic break_request_enable;
		logic cycle_type_a;
		logic cycle_qualify_a_enable;
		logic cycle_type_b;
		logic cycle_qualify_b_enable;
	} ctrl_t;

	typedef struct packed {
		logic a_hit;     // raw comparator a address match
		logic b_hit;     // raw comparator b address match
		logic is_read;   // bus cycle is a read
		logic store;     // trace word stored this cycle
	} bus_event_t;

	typedef struct packed {
		logic tag_req;
		logic force_req;
	} brk_req_t;

endpackage

// ===== testbench/cpu_break_sink.sv
/*
 cpu break sink: far-side model that takes break requests.
 assumes brk_req pulses last one clock and are never both high.
*/
`timescale 1ns/1ps
`default_nettype none
module cpu_break_sink (
	input  wire logic                  clock,     // bus clock
	input  wire logic                  nrst,      // async reset, low
	input  wire dbg_ctrl_pkg::brk_req_t brk_req,  // break request in
	output logic [7:0]                 force_cnt, // force breaks taken
	output logic [7:0]                 tag_cnt    // tagged opcodes run
);
	import dbg_ctrl_pkg::*;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			force_cnt <= 8'h00;
			tag_cnt   <= 8'h00;
		end else begin
			// instruction finishes first, then background entry
			if (brk_req.force_req)
				force_cnt <= force_cnt + 8'h01;
			// tag rides the opcode; every tagged opcode runs here
			if (brk_req.tag_req)
				tag_cnt <= tag_cnt + 8'h01;
		end
	end
endmodule
`default_nettype wire

// ===== testbench/debug_run_control_break_tb_top.sv
/*
 testbench for dbg_run_control: register tasks and directed runs.
 assumes fifo_depth of 4 and status layout {a,b,run,0,count}.
*/
`timescale 1ns/1ps
`default_nettype none
module debug_run_control_break_tb_top;
	import dbg_ctrl_pkg::*;
	logic             clock = 1'b0;
	logic             nrst = 1'b0;
	logic [addr_w-1:0] addr = '0;
	logic [7:0]       wdata = 8'h00;
	logic             wr = 1'b0;
	logic             rd = 1'b0;
	logic             secured = 1'b0;
	logic             begin_trace = 1'b0;
	logic             trigger_hit = 1'b0;
	bus_event_t       bus_event = '0;
	logic [7:0]       rdata, force_cnt, tag_cnt;
	logic             armed, match_a, match_b, run_active_flag;
	brk_req_t         brk_req;
	int               miscompares = 0;
	int               samples_checked = 0;
	// ctrl, event {a,b,read,store}, expected {match_a,match_b}
	logic [7:0]       qc [6] = '{8'hcc, 8'hcc, 8'hc8, 8'hc1, 8'hc1, 8'hc0};
	logic [3:0]       qe [6] = '{4'h8, 4'ha, 4'h8, 4'h6, 4'h4, 4'h6};
	logic [1:0]       qx [6] = '{2'h0, 2'h2, 2'h2, 2'h0, 2'h1, 2'h1};

	always #4 clock = ~clock;

	dbg_run_control #(.fifo_depth(4)) u_dut (.clock(clock), .nrst(nrst),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.secured(secured), .begin_trace(begin_trace),
		.bus_event(bus_event), .trigger_hit(trigger_hit), .armed(armed),
		.match_a(match_a), .match_b(match_b),
		.run_active_flag(run_active_flag), .brk_req(brk_req));
	cpu_break_sink u_cpu (.clock(clock), .nrst(nrst), .brk_req(brk_req),
		.force_cnt(force_cnt), .tag_cnt(tag_cnt));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rd_reg(input logic [1:0] a, input logic [7:0] exp);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1;
		check(rdata, exp);
	endtask
	// one-cycle event pulse, then outputs settle after the next edge
	task automatic pulse(input logic [3:0] e, input logic t);
		@(posedge clock);
		bus_event <= e;
		trigger_hit <= t;
		@(posedge clock);
		bus_event <= 4'h0;
		trigger_hit <= 1'b0;
		#1;
	endtask
	task automatic end_sim();
		$display("miscompares %0d samples_checked %0d", miscompares,
			samples_checked);
		if (miscompares == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge clock);
		miscompares++;
		end_sim();
	end

	initial begin
		repeat (5) @(posedge clock);
		nrst <= 1'b1;
		rd_reg(ctrl_offset, ctrl_reset);
		@(posedge clock) secured <= 1'b1;
		wr_reg(ctrl_offset, 8'h80);
		rd_reg(ctrl_offset, 8'h00);
		@(posedge clock) secured <= 1'b0;
		wr_reg(ctrl_offset, 8'h80);
		rd_reg(ctrl_offset, 8'h80);
		wr_reg(ctrl_offset, 8'hd0);
		check({7'h0, armed & run_active_flag}, 8'h01);
		pulse(4'h0, 1'b1);
		check({6'h0, brk_req}, 8'h01);
		check({7'h0, armed}, 8'h00);
		wr_reg(ctrl_offset, 8'hf0);
		pulse(4'h0, 1'b1);
		check({6'h0, brk_req}, 8'h02);
		wr_reg(ctrl_offset, 8'he0);
		pulse(4'h0, 1'b1);
		check({6'h0, brk_req, armed}, 8'h00);
		wr_reg(ctrl_offset, 8'hd0);
		wr_reg(ctrl_offset, 8'h90);
		pulse(4'h0, 1'b1);
		check({5'h0, brk_req, run_active_flag}, 8'h00);
		wr_reg(ctrl_offset, 8'hd0);
		wr_reg(ctrl_offset, 8'h50);
		check({7'h0, armed}, 8'h00);
		// begin trace: break on the store that fills the fifo
		@(posedge clock) begin_trace <= 1'b1;
		wr_reg(ctrl_offset, 8'hd0);
		repeat (3) pulse(4'h1, 1'b0);
		check({6'h0, brk_req}, 8'h00);
		// a trigger does not end a begin-trace run
		pulse(4'h0, 1'b1);
		check({5'h0, brk_req, armed}, 8'h01);
		pulse(4'h1, 1'b0);
		check({5'h0, brk_req, armed}, 8'h02);
		rd_reg(status_offset, 8'h04);
		wr_reg(ctrl_offset, 8'hc0);
		rd_reg(status_offset, 8'h20);
		pulse(4'h1, 1'b0);
		rd_reg(status_offset, 8'h21);
		@(posedge clock) begin_trace <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			wr_reg(ctrl_offset, qc[i]);
			pulse(qe[i], 1'b0);
			check({6'h0, match_a, match_b}, {6'h0, qx[i]});
		end
		rd_reg(2'h3, 8'h00);
		check(force_cnt, 8'h02);
		check(tag_cnt, 8'h01);
		end_sim();
	end
endmodule
`default_nettype wire
